// ==== core/ipa_pkg.sv ====
// shared constants and types of the i2c register pointer access block
package ipa_pkg;

  typedef logic [15:0] ipa_word_t;

  // register reset values
  localparam ipa_word_t CONV_RST  = 16'h0000;
  localparam ipa_word_t CFG_RST   = 16'h8583;
  localparam ipa_word_t LOWER_RST = 16'h8000;
  localparam ipa_word_t UPPER_RST = 16'h7fff;
  localparam logic [7:0] PTR_RST  = 8'h00;

  // clipping codes of the conversion result
  localparam ipa_word_t POS_FULL = 16'h7fff;
  localparam ipa_word_t NEG_FULL = 16'h8000;
  localparam int        RES_MSB  = 15;

  // pointer decode
  localparam logic [1:0] PTR_CONV  = 2'h0;
  localparam logic [1:0] PTR_CFG   = 2'h1;
  localparam logic [1:0] PTR_LOWER = 2'h2;
  localparam logic [1:0] PTR_UPPER = 2'h3;

  // bus framing
  localparam logic [6:0] TARGET_ADDR = 7'h48;
  localparam logic       DIR_WRITE   = 1'b0;
  localparam logic       DIR_READ    = 1'b1;
  localparam logic [2:0] LAST_BIT    = 3'h7;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_PTR   = 4'h2,
    ST_WDATA = 4'h3,
    ST_ACK   = 4'h4,
    ST_RDATA = 4'h5,
    ST_RACK  = 4'h6
  } ipa_state_t;

  // register write carried from the link side to the system side
  typedef struct packed {
    logic [1:0] ptr;
    ipa_word_t  data;
  } ipa_wr_t;

endpackage : ipa_pkg

// ==== core/ipa_word_cdc.sv ====
// toggle handshake carrying one word between two clock domains
`timescale 1ns/1ps
module ipa_word_cdc #(
  parameter int W = 16
) (
  input  wire logic         src_clk_i,
  input  wire logic         src_rst_i,
  input  wire logic         src_load_i,
  input  wire logic [W-1:0] src_data_i,
  output logic              src_busy_o,
  input  wire logic         dst_clk_i,
  input  wire logic         dst_rst_i,
  output logic              dst_valid_o,
  output logic [W-1:0]      dst_data_o
);

  logic         req_tgl;
  logic [W-1:0] hold;
  logic         ack_m;
  logic         ack_s;
  logic         req_m;
  logic         req_s;
  logic         req_d;
  logic         ack_tgl;
  wire          req_edge = req_s ^ req_d;

  assign src_busy_o = req_tgl ^ ack_s;

  // ---------------------------------------------------------------
  // source side: hold stays still until the far side has taken it
  // ---------------------------------------------------------------
  always_ff @(posedge src_clk_i) begin
    if (src_rst_i) begin
      req_tgl <= 1'b0;
      hold    <= '0;
      ack_m   <= 1'b0;
      ack_s   <= 1'b0;
    end else begin
      ack_m <= ack_tgl;
      ack_s <= ack_m;
      if (src_load_i && !src_busy_o) begin
        hold    <= src_data_i;
        req_tgl <= ~req_tgl;
      end
    end
  end

  // ---------------------------------------------------------------
  // destination side
  // ---------------------------------------------------------------
  always_ff @(posedge dst_clk_i) begin
    if (dst_rst_i) begin
      req_m       <= 1'b0;
      req_s       <= 1'b0;
      req_d       <= 1'b0;
      ack_tgl     <= 1'b0;
      dst_valid_o <= 1'b0;
      dst_data_o  <= '0;
    end else begin
      req_m       <= req_tgl;
      req_s       <= req_m;
      req_d       <= req_s;
      dst_valid_o <= req_edge;
      if (req_edge) begin
        dst_data_o <= hold;
        ack_tgl    <= req_s;
      end
    end
  end

endmodule : ipa_word_cdc

// ==== core/ipa_top.sv ====
// i2c target with pointer-selected 16-bit registers
`timescale 1ns/1ps
module ipa_top #(
  parameter int RAW_W = 18
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_link_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic              conv_done_i,
  input  wire logic [RAW_W-1:0]  conv_raw_i,
  output ipa_pkg::ipa_word_t     conv_result_o,
  output ipa_pkg::ipa_word_t     cfg_o,
  output ipa_pkg::ipa_word_t     lower_compare_limit_o,
  output ipa_pkg::ipa_word_t     upper_compare_limit_o
);
  import ipa_pkg::*;

  function automatic logic [7:0] byte_of(input ipa_word_t w,
                                         input logic lo);
    byte_of = lo ? w[7:0] : w[15:8];
  endfunction : byte_of

  // ---------------------------------------------------------------
  // system domain: conversion result with clipping
  // ---------------------------------------------------------------
  ipa_word_t conversion_result;
  logic      conv_dirty;
  logic      conv_busy;
  wire       raw_fits = (&conv_raw_i[RAW_W-1:RES_MSB]) ||
                        (~|conv_raw_i[RAW_W-1:RES_MSB]);
  wire       raw_neg  = conv_raw_i[RAW_W-1];
  wire ipa_word_t raw_clip = raw_fits ? conv_raw_i[RES_MSB:0] :
                             (raw_neg ? NEG_FULL : POS_FULL);
  wire       conv_load = conv_dirty && !conv_busy;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      conversion_result <= CONV_RST;
      conv_dirty        <= 1'b0;
    end else if (conv_done_i) begin
      conversion_result <= raw_clip;
      conv_dirty        <= 1'b1;
    end else if (conv_load) begin
      conv_dirty <= 1'b0;
    end
  end

  assign conv_result_o = conversion_result;

  // ---------------------------------------------------------------
  // link domain reset and pin synchronisers
  // ---------------------------------------------------------------
  logic rst_m;
  logic link_rst;
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;

  always_ff @(posedge clk_link_i) begin
    rst_m    <= sys_rst_i;
    link_rst <= rst_m;
  end

  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
    end
  end

  wire scl_hold  = scl_s && scl_d;
  wire start_det = scl_hold && sda_d && !sda_s;
  wire stop_det  = scl_hold && !sda_d && sda_s;
  wire scl_rise  = scl_s && !scl_d;
  wire scl_fall  = !scl_s && scl_d;

  // ---------------------------------------------------------------
  // link domain registers
  // ---------------------------------------------------------------
  ipa_state_t state, ack_next;
  logic [2:0] bit_cnt;
  logic       got_byte;
  logic [7:0] shift_q;
  logic [7:0] tx_sh;
  logic       byte_lo;
  logic [7:0] data_hi;
  ipa_word_t  rd_word;
  logic [7:0] register_select_pointer;
  ipa_word_t  conv_link, cfg_link, lower_link, upper_link;
  logic       wr_load;
  ipa_wr_t    wr_word;
  logic       conv_rx_valid;
  ipa_word_t  conv_rx;

  wire [1:0] ptr_sel  = register_select_pointer[1:0];
  wire       addr_hit = shift_q[7:1] == TARGET_ADDR;
  wire       dir_bit  = shift_q[0];
  wire ipa_word_t sel_word =
    (ptr_sel == PTR_CONV)  ? conv_link  :
    (ptr_sel == PTR_CFG)   ? cfg_link   :
    (ptr_sel == PTR_LOWER) ? lower_link : upper_link;
  wire [7:0] first_byte = byte_of(rd_word, 1'b0);
  wire [7:0] again_byte = byte_of(rd_word, !byte_lo);
  wire       rack_nack  = (state == ST_RACK) && scl_rise && sda_s;

  // ---------------------------------------------------------------
  // link protocol next state
  // ---------------------------------------------------------------
  ipa_state_t next_state, next_ack;
  logic [2:0] next_cnt;
  logic       next_got, next_oe, next_lo, next_commit;
  logic [7:0] next_shift, next_tx, next_hi, next_ptr;
  ipa_word_t  next_rd;

  always_comb begin
    next_state  = state;
    next_ack    = ack_next;
    next_cnt    = bit_cnt;
    next_got    = got_byte;
    next_shift  = shift_q;
    next_tx     = tx_sh;
    next_oe     = sda_oe_o;
    next_lo     = byte_lo;
    next_hi     = data_hi;
    next_rd     = rd_word;
    next_ptr    = register_select_pointer;
    next_commit = 1'b0;
    if (start_det) begin
      next_state = ST_ADDR;
      next_cnt   = '0;
      next_got   = 1'b0;
      next_oe    = 1'b0;
    end else if (stop_det) begin
      next_state = ST_IDLE;
      next_got   = 1'b0;
      next_oe    = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            next_shift = {shift_q[6:0], sda_s};
            next_cnt   = bit_cnt + 3'h1;
            next_got   = (bit_cnt == LAST_BIT);
          end else if (scl_fall && got_byte) begin
            next_got   = 1'b0;
            next_cnt   = '0;
            next_oe    = 1'b1;
            next_state = ST_ACK;
            case (state)
              ST_ADDR: begin
                if (!addr_hit) begin
                  next_oe    = 1'b0;
                  next_state = ST_IDLE;
                end else if (dir_bit == DIR_READ) begin
                  next_ack = ST_RDATA;
                  next_rd  = sel_word;
                  next_lo  = 1'b0;
                end else begin
                  next_ack = ST_PTR;
                end
              end
              ST_PTR: begin
                next_ptr = shift_q;
                next_ack = ST_WDATA;
                next_lo  = 1'b0;
              end
              default: begin
                next_ack = ST_WDATA;
                if (!byte_lo) begin
                  next_hi = shift_q;
                  next_lo = 1'b1;
                end else begin
                  next_lo     = 1'b0;
                  next_commit = (ptr_sel != PTR_CONV);
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_state = ack_next;
            next_cnt   = '0;
            if (ack_next == ST_RDATA) begin
              next_tx = first_byte;
              next_oe = !first_byte[7];
            end else begin
              next_oe = 1'b0;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == LAST_BIT) begin
              next_oe    = 1'b0;
              next_state = ST_RACK;
            end else begin
              next_cnt = bit_cnt + 3'h1;
              next_tx  = {tx_sh[6:0], 1'b0};
              next_oe  = !tx_sh[6];
            end
          end
        end
        ST_RACK: begin
          if (rack_nack) begin
            next_state = ST_IDLE;
          end else if (scl_fall) begin
            next_lo    = !byte_lo;
            next_tx    = again_byte;
            next_oe    = !again_byte[7];
            next_cnt   = '0;
            next_state = ST_RDATA;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      state    <= ST_IDLE;
      ack_next <= ST_IDLE;
      bit_cnt  <= '0;
      got_byte <= 1'b0;
      shift_q  <= '0;
      tx_sh    <= '0;
      sda_oe_o <= 1'b0;
      byte_lo  <= 1'b0;
      data_hi  <= '0;
      rd_word  <= '0;
    end else begin
      state    <= next_state;
      ack_next <= next_ack;
      bit_cnt  <= next_cnt;
      got_byte <= next_got;
      shift_q  <= next_shift;
      tx_sh    <= next_tx;
      sda_oe_o <= next_oe;
      byte_lo  <= next_lo;
      data_hi  <= next_hi;
      rd_word  <= next_rd;
    end
  end

  // open drain: the pin is only ever pulled low
  always_ff @(posedge clk_link_i) begin
    sda_o <= 1'b0;
  end

  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      register_select_pointer <= PTR_RST;
    end else begin
      register_select_pointer <= next_ptr;
    end
  end

  // ---------------------------------------------------------------
  // link-side register copies and write commit
  // ---------------------------------------------------------------
  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      cfg_link   <= CFG_RST;
      lower_link <= LOWER_RST;
      upper_link <= UPPER_RST;
      conv_link  <= CONV_RST;
      wr_load    <= 1'b0;
      wr_word    <= '0;
    end else begin
      wr_load <= next_commit;
      if (next_commit) begin
        wr_word <= '{ptr: ptr_sel, data: {data_hi, shift_q}};
        case (ptr_sel)
          PTR_CFG:   cfg_link   <= {data_hi, shift_q};
          PTR_LOWER: lower_link <= {data_hi, shift_q};
          PTR_UPPER: upper_link <= {data_hi, shift_q};
          default:   ;
        endcase
      end
      if (conv_rx_valid) begin
        conv_link <= conv_rx;
      end
    end
  end

  // ---------------------------------------------------------------
  // domain crossings
  // ---------------------------------------------------------------
  logic    wr_rx_valid;
  ipa_wr_t wr_rx;

  ipa_word_cdc #(.W($bits(ipa_word_t))) u_conv_cdc (
    .src_clk_i   (clk_sys_i),
    .src_rst_i   (sys_rst_i),
    .src_load_i  (conv_load),
    .src_data_i  (conversion_result),
    .src_busy_o  (conv_busy),
    .dst_clk_i   (clk_link_i),
    .dst_rst_i   (link_rst),
    .dst_valid_o (conv_rx_valid),
    .dst_data_o  (conv_rx)
  );

  ipa_word_cdc #(.W($bits(ipa_wr_t))) u_wr_cdc (
    .src_clk_i   (clk_link_i),
    .src_rst_i   (link_rst),
    .src_load_i  (wr_load),
    .src_data_i  (wr_word),
    .src_busy_o  (),
    .dst_clk_i   (clk_sys_i),
    .dst_rst_i   (sys_rst_i),
    .dst_valid_o (wr_rx_valid),
    .dst_data_o  (wr_rx)
  );

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cfg_o                 <= CFG_RST;
      lower_compare_limit_o <= LOWER_RST;
      upper_compare_limit_o <= UPPER_RST;
    end else if (wr_rx_valid) begin
      case (wr_rx.ptr)
        PTR_CFG:   cfg_o                 <= wr_rx.data;
        PTR_LOWER: lower_compare_limit_o <= wr_rx.data;
        PTR_UPPER: upper_compare_limit_o <= wr_rx.data;
        default:   ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_clip_high: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    conv_done_i && !raw_fits && !raw_neg |=>
      conversion_result == POS_FULL)
    else $error("positive overrange not clipped");

  a_clip_low: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    conv_done_i && !raw_fits && raw_neg |=>
      conversion_result == NEG_FULL)
    else $error("negative overrange not clipped");

  a_result_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !conv_done_i |=> $stable(conversion_result))
    else $error("conversion result changed without a conversion");

  a_ptr_load: assert property (@(posedge clk_link_i) disable iff (link_rst)
    state == ST_PTR && scl_fall && got_byte && !start_det && !stop_det |=>
      register_select_pointer == $past(shift_q) && sda_oe_o)
    else $error("pointer byte not loaded or not acked");

  a_ptr_keep: assert property (@(posedge clk_link_i) disable iff (link_rst)
    state != ST_PTR |=> $stable(register_select_pointer))
    else $error("pointer changed outside a pointer byte");

  a_addr_dir: assert property (@(posedge clk_link_i) disable iff (link_rst)
    state == ST_ADDR && scl_fall && got_byte && addr_hit &&
    !start_det && !stop_det |=>
      ack_next == ($past(dir_bit) ? ST_RDATA : ST_PTR))
    else $error("direction bit misrouted");

  a_nack_release: assert property (@(posedge clk_link_i) disable iff (link_rst)
    rack_nack && !start_det && !stop_det |=>
      !sda_oe_o && state == ST_IDLE ##1 !sda_oe_o)
    else $error("data still driven after nack");

  a_stop_release: assert property (@(posedge clk_link_i) disable iff (link_rst)
    stop_det |=> !sda_oe_o && state == ST_IDLE)
    else $error("data still driven after stop");

  a_msb_first: assert property (@(posedge clk_link_i) disable iff (link_rst)
    state == ST_RDATA && scl_fall && bit_cnt != LAST_BIT &&
    !start_det && !stop_det |=> sda_oe_o == !$past(tx_sh[6]))
    else $error("read bit order wrong");

  a_ack_hold: assert property (@(posedge clk_link_i) disable iff (link_rst)
    $rose(state == ST_ACK) |-> sda_oe_o throughout
      (state == ST_ACK)[*2])
    else $error("acknowledge not held");

  a_cfg_commit: assert property (@(posedge clk_link_i) disable iff (link_rst)
    next_commit && ptr_sel == PTR_CFG |=>
      cfg_link == {$past(data_hi), $past(shift_q)})
    else $error("config write bytes misordered");

endmodule : ipa_top

// ==== bench/ipa_ctl_model.sv ====
// i2c bus controller model driving the target's clock and data lines
`timescale 1ns/1ps
module ipa_ctl_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // ------------------------------------------------------------------
  // bus conditions and bit transfers
  // ------------------------------------------------------------------
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  // quarter of a bus clock period
  task automatic hq();
    repeat (2) @(negedge clk_i);
  endtask : hq

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_pull_o = 1'b0;
    hq();
    scl_o = 1'b1;
    hq();
    sda_pull_o = 1'b1;
    hq();
    scl_o = 1'b0;
    hq();
  endtask : start

  task automatic stop();
    sda_pull_o = 1'b1;
    hq();
    scl_o = 1'b1;
    hq();
    sda_pull_o = 1'b0;
    hq();
  endtask : stop

  // data only changes while scl is low, sampled mid-high
  task automatic bit_xfer(input logic b, output logic s);
    sda_pull_o = ~b;
    hq();
    scl_o = 1'b1;
    hq();
    s = sda_i;
    hq();
    scl_o = 1'b0;
    hq();
  endtask : bit_xfer

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  task automatic rd_byte(input logic ack_it, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      b[i] = s;
    end
    bit_xfer(~ack_it, s);
  endtask : rd_byte
endmodule : ipa_ctl_model

// ==== bench/ipa_top_tb.sv ====
// self-checking testbench of the i2c register pointer access block
`timescale 1ns/1ps
module ipa_top_tb;
  import ipa_pkg::*;
  // ------------------------------------------------------------------
  // clocks, wiring and instances
  // ------------------------------------------------------------------
  logic        clk_sys   = 1'b0;
  logic        clk_link  = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        conv_done = 1'b0;
  logic [17:0] conv_raw  = 18'h00000;
  logic        scl;
  logic        ctl_pull;
  logic        dev_sda;
  logic        dev_oe;
  wire         sda_bus;
  ipa_word_t   conv_res;
  ipa_word_t   cfg;
  ipa_word_t   lower_lim;
  ipa_word_t   upper_lim;
  int          n_fail      = 0;
  int          checks_done = 0;

  always #20 clk_sys = ~clk_sys;
  initial begin
    #1.3;
    forever #3 clk_link = ~clk_link;
  end

  // pull-up wire: low when either party pulls it
  assign sda_bus = ~((dev_oe & ~dev_sda) | ctl_pull);

  ipa_top #(.RAW_W(18)) u_dut (
    .clk_sys_i             (clk_sys),
    .sys_rst_i             (sys_rst),
    .clk_link_i            (clk_link),
    .scl_i                 (scl),
    .sda_i                 (sda_bus),
    .sda_o                 (dev_sda),
    .sda_oe_o              (dev_oe),
    .conv_done_i           (conv_done),
    .conv_raw_i            (conv_raw),
    .conv_result_o         (conv_res),
    .cfg_o                 (cfg),
    .lower_compare_limit_o (lower_lim),
    .upper_compare_limit_o (upper_lim)
  );

  ipa_ctl_model u_ctl (
    .clk_i      (clk_sys),
    .sda_i      (sda_bus),
    .scl_o      (scl),
    .sda_pull_o (ctl_pull)
  );

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string nm, input ipa_word_t got,
                       input ipa_word_t exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic write_reg(input logic [7:0] ptr, input ipa_word_t d);
    logic a0, a1, a2, a3;
    u_ctl.start();
    u_ctl.wr_byte({TARGET_ADDR, DIR_WRITE}, a0);
    u_ctl.wr_byte(ptr, a1);
    u_ctl.wr_byte(d[15:8], a2);
    u_ctl.wr_byte(d[7:0], a3);
    u_ctl.stop();
    check("write acks", {12'h000, a0, a1, a2, a3}, 16'h000f);
    cyc(12);
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ptr, input logic set_ptr,
                          output ipa_word_t d);
    logic       a0, a1;
    logic [7:0] hi, lo;
    if (set_ptr) begin
      u_ctl.start();
      u_ctl.wr_byte({TARGET_ADDR, DIR_WRITE}, a0);
      u_ctl.wr_byte(ptr, a1);
      check("pointer acks", {14'h0000, a0, a1}, 16'h0003);
    end
    u_ctl.start();
    u_ctl.wr_byte({TARGET_ADDR, DIR_READ}, a0);
    check("read address ack", {15'h0000, a0}, 16'h0001);
    u_ctl.rd_byte(1'b1, hi);
    u_ctl.rd_byte(1'b0, lo);
    u_ctl.stop();
    d = {hi, lo};
  endtask : read_reg

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    ipa_word_t d;
    check("cfg reset", cfg, CFG_RST);
    check("lower reset", lower_lim, LOWER_RST);
    check("upper reset", upper_lim, UPPER_RST);
    check("conv reset", conv_res, 16'h0000);
    read_reg(8'h00, 1'b0, d);
    check("conv read at reset", d, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_writes();
    ipa_word_t d;
    logic      a0, a1;
    write_reg(8'h01, 16'ha5c3);
    check("cfg out", cfg, 16'ha5c3);
    read_reg(8'h01, 1'b1, d);
    check("cfg read", d, 16'ha5c3);
    write_reg(8'h02, 16'h8001);
    write_reg(8'h03, 16'h7ffe);
    check("lower out", lower_lim, 16'h8001);
    check("upper out", upper_lim, 16'h7ffe);
    read_reg(8'h02, 1'b1, d);
    check("lower read", d, 16'h8001);
    read_reg(8'h03, 1'b1, d);
    check("upper read", d, 16'h7ffe);
    read_reg(8'h00, 1'b0, d);
    check("pointer kept", d, 16'h7ffe);
    check("cfg unchanged", cfg, 16'ha5c3);
    // pointer-only frame closed by stop, then a plain read frame
    u_ctl.start();
    u_ctl.wr_byte({TARGET_ADDR, DIR_WRITE}, a0);
    u_ctl.wr_byte(8'h01, a1);
    u_ctl.stop();
    check("pointer only acks", {14'h0000, a0, a1}, 16'h0003);
    read_reg(8'h00, 1'b0, d);
    check("pointer after stop", d, 16'ha5c3);
    $display("test writes done");
  endtask : t_writes

  logic [17:0] raw_tab [8] = '{18'h00001, 18'h3ffff, 18'h00000, 18'h07fff,
                               18'h08000, 18'h1ffff, 18'h38000, 18'h37fff};
  ipa_word_t   exp_tab [8] = '{16'h0001, 16'hffff, 16'h0000, 16'h7fff,
                               16'h7fff, 16'h7fff, 16'h8000, 16'h8000};

  task automatic t_conv();
    ipa_word_t d;
    for (int i = 0; i < 8; i++) begin
      conv_done = 1'b1;
      conv_raw  = raw_tab[i];
      cyc(1);
      conv_done = 1'b0;
      check("conv code", conv_res, exp_tab[i]);
      cyc(2);
    end
    cyc(20);
    // data written to the conversion pointer is acked but discarded
    write_reg(8'h00, 16'h1234);
    read_reg(8'h00, 1'b1, d);
    check("conv read", d, 16'h8000);
    $display("test conversion done");
  endtask : t_conv

  task automatic t_abort();
    logic [7:0] b;
    logic       a;
    u_ctl.start();
    u_ctl.wr_byte({TARGET_ADDR, DIR_READ}, a);
    u_ctl.rd_byte(1'b0, b);
    check("first byte", {8'h00, b}, 16'h0080);
    u_ctl.rd_byte(1'b0, b);
    check("released after nack", {8'h00, b}, 16'h00ff);
    u_ctl.stop();
    u_ctl.start();
    u_ctl.wr_byte({TARGET_ADDR ^ 7'h01, DIR_WRITE}, a);
    u_ctl.stop();
    check("foreign address", {15'h0000, a}, 16'h0000);
    $display("test abort done");
  endtask : t_abort

  initial begin
    // the scenarios need about 160 us of bus traffic
    #500000;
    n_fail++;
    wrap_up();
  end

  initial begin
    cyc(4);
    sys_rst = 1'b0;
    cyc(5);
    t_reset();
    t_writes();
    t_conv();
    t_abort();
    wrap_up();
  end
endmodule : ipa_top_tb
